/* File: core/filter_output_stage.sv */
// output stage: gain, rounding, formatting and terminal counter
`timescale 1ns/1ps
`default_nettype none
module filter_output_stage
    import filter_out_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [5:0] adr_in,
    input wire logic [3:0] sel_in,
    input wire logic [31:0] dat_in,
    output logic [31:0] dat_out,
    output logic ack_out,
    input wire logic sync_n_in,
    input wire logic sample_valid_in,
    input wire path_pair_t paths_in,
    output logic [15:0] path_a_word_out,
    output logic [15:0] path_b_word_out,
    output logic valid_strobe_out,
    output logic path_a_overflow_out,
    output logic path_b_overflow_out,
    output logic terminal_count_strobe_out
);
    function automatic logic [5:0] keep_bits(input logic [6:0] code);
        unique case (code)
            RND_8: keep_bits = 6'd8;
            RND_10: keep_bits = 6'd10;
            RND_12: keep_bits = 6'd12;
            RND_14: keep_bits = 6'd14;
            RND_16: keep_bits = 6'd16;
            RND_20: keep_bits = 6'd20;
            RND_24: keep_bits = 6'd24;
            default: keep_bits = 6'd0;
        endcase
    endfunction

    // returns {overflow, 32-bit rounded and saturated word}
    function automatic logic [32:0] gain_path(input logic [31:0] x, input gain_cfg_t g);
        logic signed [55:0] p;
        logic signed [55:0] h;
        logic [5:0] n;
        logic ovf;
        logic [31:0] r;
        p = $signed({{24{x[31]}}, x}) * $signed({51'h0, 1'b1, g.frac});
        p = p <<< g.exp;
        p = p >>> 4;
        n = keep_bits(g.round);
        h = (n == 6'd0) ? 56'sh0 : (56'sh1 <<< (6'd31 - n));
        p = p + h;
        ovf = (p[55:31] != {25{p[55]}});
        r = ovf ? (p[55] ? 32'h80000000 : 32'h7fffffff) : p[31:0];
        if (n != 6'd0)
        begin
            r = r & (32'hffffffff << (6'd32 - n));
        end
        gain_path = {ovf, r};
    endfunction

    function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {a[31], a} + {b[31], b};
        if (s[32] != s[31])
        begin
            sat_add = s[32] ? 32'h80000000 : 32'h7fffffff;
        end
        else
        begin
            sat_add = s[31:0];
        end
    endfunction

    function automatic logic [31:0] neg_sat(input logic [31:0] a);
        neg_sat = (a == 32'h80000000) ? 32'h7fffffff : (32'h0 - a);
    endfunction

    logic [15:0] period_q;
    logic [15:0] gain_reg_q;
    logic [15:0] format_q;
    logic sync_dis_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic acc;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] wmask;

    assign acc = cyc_in && stb_in && !ack_q;
    assign wr_lo = acc && we_in && sel_in[0];
    assign wr_hi = acc && we_in && sel_in[1];
    assign wmask = {{8{wr_hi}}, {8{wr_lo}}};

    // bus answer one cycle after the strobe, dropped the next cycle
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= acc;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            period_q <= PERIOD_RESET;
            gain_reg_q <= GAIN_RESET;
            format_q <= FORMAT_RESET;
            sync_dis_q <= 1'b0;
        end
        else
        begin
            unique case (adr_in[5:2])
                IDX_PERIOD: period_q <= (period_q & ~wmask) | (dat_in[15:0] & wmask);
                IDX_GAIN: gain_reg_q <= (gain_reg_q & ~wmask) | (dat_in[15:0] & wmask);
                IDX_FORMAT: format_q <= (format_q & ~wmask) | (dat_in[15:0] & wmask);
                IDX_CONTROL:
                begin
                    if (wr_lo)
                    begin
                        sync_dis_q <= dat_in[CTRL_SYNC_DIS];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rdata_q <= 32'h0;
        end
        else if (acc)
        begin
            unique case (adr_in[5:2])
                IDX_PERIOD: rdata_q <= {16'h0, period_q};
                IDX_GAIN: rdata_q <= {16'h0, gain_reg_q};
                IDX_FORMAT: rdata_q <= {16'h0, format_q};
                IDX_CONTROL: rdata_q <= {29'h0, path_b_overflow_out, path_a_overflow_out,
                                         sync_dis_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    assign ack_out = ack_q;
    assign dat_out = rdata_q;

    // sync pin: three stages, change accepted once stages two and three agree
    logic sync_s1_q;
    logic sync_s2_q;
    logic sync_s3_q;
    logic sync_lvl_q;
    logic load;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
            sync_s3_q <= 1'b1;
            sync_lvl_q <= 1'b1;
        end
        else
        begin
            sync_s1_q <= sync_n_in;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
            if (sync_s2_q == sync_s3_q)
            begin
                sync_lvl_q <= sync_s3_q;
            end
        end
    end

    assign load = (sync_s2_q == sync_s3_q) && !sync_s3_q && sync_lvl_q && !sync_dis_q;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] reload;
    logic tc_raw_q;
    logic [TC_PIPE-1:0] tc_dly_q;

    assign reload = {period_q, CNT_LOW_FILL};

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cnt_q <= '0;
        end
        else if (load || cnt_q == '0)
        begin
            cnt_q <= reload;
        end
        else
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            tc_raw_q <= 1'b0;
            tc_dly_q <= '0;
        end
        else
        begin
            tc_raw_q <= load || (cnt_q == '0);
            tc_dly_q <= {tc_dly_q[TC_PIPE-2:0], tc_raw_q};
        end
    end

    assign terminal_count_strobe_out = tc_dly_q[TC_PIPE-1];

    // gain setting adopted only on a data clock so a sample never sees a half change
    gain_cfg_t gain_act_q;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            gain_act_q <= '0;
        end
        else if (sample_valid_in)
        begin
            gain_act_q <= gain_cfg_t'(gain_reg_q[14:0]);
        end
    end

    // clock phase for even and odd sample time, restarted by sync
    logic [2:0] phase_q;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in || load)
        begin
            phase_q <= 3'h0;
        end
        else
        begin
            phase_q <= phase_q + 3'h1;
        end
    end

    logic [32:0] ga;
    logic [32:0] gb;
    logic [1:0] neg_sel;
    logic odd_time;
    logic [31:0] fa;
    logic [31:0] fb;
    logic [31:0] bsrc;
    logic [15:0] a_word;
    logic [15:0] b_word;
    logic [1:0] mux_sel;
    logic wide_out;

    assign ga = gain_path(paths_in.a, gain_act_q);
    assign gb = gain_path(paths_in.b, gain_act_q);
    assign neg_sel = format_q[FMT_NEG_LSB +: 2];
    assign mux_sel = format_q[FMT_MUX_LSB +: 2];
    assign wide_out = format_q[FMT_WIDE_OUT];

    always_comb
    begin
        odd_time = 1'b0;
        if (neg_sel != 2'h0)
        begin
            odd_time = phase_q[neg_sel - 2'h1];
        end
        fa = ((neg_sel != 2'h0) && !odd_time) ? neg_sat(ga[31:0]) : ga[31:0];
        fb = ((neg_sel != 2'h0) && odd_time) ? neg_sat(gb[31:0]) : gb[31:0];
        bsrc = format_q[FMT_PATH_ADD] ? sat_add(fa, fb) : fb;
        if (wide_out)
        begin
            a_word = bsrc[31:16];
            b_word = {bsrc[15:8], 8'h00};
        end
        else if (mux_sel != MUX_OFF)
        begin
            a_word = fa[31:16];
            b_word = 16'h0000;
        end
        else
        begin
            a_word = fa[31:16];
            b_word = bsrc[31:16];
        end
    end

    logic [15:0] a_out_q;
    logic [15:0] b_out_q;
    logic [15:0] pend_q;
    logic mux_pend_q;
    logic valid_q;
    logic ovf_a_q;
    logic ovf_b_q;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            a_out_q <= 16'h0000;
            b_out_q <= 16'h0000;
            pend_q <= 16'h0000;
            mux_pend_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else if (sample_valid_in)
        begin
            a_out_q <= a_word;
            b_out_q <= b_word;
            pend_q <= bsrc[31:16];
            mux_pend_q <= (mux_sel != MUX_OFF) && !wide_out;
            valid_q <= 1'b1;
        end
        else if (mux_pend_q)
        begin
            a_out_q <= pend_q;
            b_out_q <= 16'h0000;
            mux_pend_q <= 1'b0;
            valid_q <= 1'b1;
        end
        else
        begin
            valid_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ovf_a_q <= 1'b0;
            ovf_b_q <= 1'b0;
        end
        else if (sample_valid_in)
        begin
            ovf_a_q <= ga[32];
            ovf_b_q <= gb[32];
        end
    end

    assign path_a_word_out = a_out_q;
    assign path_b_word_out = b_out_q;
    assign path_a_overflow_out = ovf_a_q;
    assign path_b_overflow_out = ovf_b_q;
    assign valid_strobe_out = valid_q ^ format_q[FMT_VALID_INV];

    // helper: clocks since last strobe
    logic [CNT_W:0] gap_q;
    logic seen_q;
    logic [CNT_W-1:0] span_q;
    logic [CNT_W-1:0] span_prev_q;
    logic [3:0] load_age_q;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end
        else if (terminal_count_strobe_out)
        begin
            gap_q <= 21'h1;
            seen_q <= 1'b1;
        end
        else
        begin
            gap_q <= gap_q + 21'h1;
        end
    end

    // helper: preset of the count now running and of the one before, clocks since a sync load
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            span_q <= '0;
            span_prev_q <= '0;
            load_age_q <= 4'hf;
        end
        else
        begin
            if (load || cnt_q == '0)
            begin
                span_prev_q <= span_q;
                span_q <= reload;
            end
            if (load)
            begin
                load_age_q <= 4'h0;
            end
            else if (load_age_q != 4'hf)
            begin
                load_age_q <= load_age_q + 4'h1;
            end
        end
    end

    a_tc_first: assert property (@(posedge mclk_in) disable iff (rst_in)
        load |-> ##5 terminal_count_strobe_out) else $error("first strobe not 8 after sync");
    a_tc_period: assert property (@(posedge mclk_in) disable iff (rst_in)
        terminal_count_strobe_out && seen_q && load_age_q > 4'h4
        |-> gap_q == {1'b0, span_prev_q} + 21'h1) else $error("strobe period wrong");
    a_cnt_reload: assert property (@(posedge mclk_in) disable iff (rst_in)
        load |=> cnt_q == $past(reload)) else $error("counter not preset");
    a_cnt_step: assert property (@(posedge mclk_in) disable iff (rst_in)
        !load && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1'b1) else $error("counter not stepping");
    a_tc_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
        cnt_q == '0 |=> tc_raw_q) else $error("no strobe at zero");
    a_sync_ignored: assert property (@(posedge mclk_in) disable iff (rst_in)
        sync_dis_q && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("sync taken while disabled");
    a_gain_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        !sample_valid_in |=> $stable(gain_act_q)) else $error("gain changed off data clock");
    a_ovf_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        sample_valid_in && ga[32] |=> path_a_overflow_out) else $error("overflow not flagged");
    a_mux_order: assert property (@(posedge mclk_in) disable iff (rst_in)
        sample_valid_in && mux_sel != MUX_OFF && !wide_out
        |=> valid_q && path_b_word_out == 16'h0000 ##1 valid_q && a_out_q == $past(pend_q))
        else $error("mux order broken");
    a_valid_pol: assert property (@(posedge mclk_in) disable iff (rst_in)
        sample_valid_in ##1 $stable(format_q) |-> valid_strobe_out == !format_q[FMT_VALID_INV])
        else $error("valid polarity");
    c_sync_load: cover property (@(posedge mclk_in) disable iff (rst_in) load ##5 terminal_count_strobe_out);
    c_overflow: cover property (@(posedge mclk_in) disable iff (rst_in) path_b_overflow_out);
    c_mux_pair: cover property (@(posedge mclk_in) disable iff (rst_in) mux_pend_q ##1 valid_q);
endmodule
`default_nettype wire

/* File: pkg/filter_out_pkg.sv */
// constants and carrier types for the filter output stage
package filter_out_pkg;
    localparam logic [3:0] IDX_PERIOD = 4'h5;
    localparam logic [3:0] IDX_GAIN = 4'h6;
    localparam logic [3:0] IDX_FORMAT = 4'h7;
    localparam logic [3:0] IDX_CONTROL = 4'h8;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [15:0] FORMAT_RESET = 16'h0000;
    localparam int GAIN_FRAC_LSB = 0;
    localparam int GAIN_EXP_LSB = 4;
    localparam int ROUND_LSB = 8;
    localparam int FMT_NEG_LSB = 0;
    localparam int FMT_WIDE_MODE = 2;
    localparam int FMT_WIDE_OUT = 3;
    localparam int FMT_MUX_LSB = 4;
    localparam int FMT_PATH_ADD = 6;
    localparam int FMT_VALID_INV = 7;
    localparam int CTRL_SYNC_DIS = 0;
    localparam int CTRL_OVF_A = 1;
    localparam int CTRL_OVF_B = 2;
    localparam int CNT_W = 20;
    localparam int TC_LATENCY = 8;
    localparam int SYNC_LATENCY = 4;
    localparam int TC_PIPE = TC_LATENCY - SYNC_LATENCY;
    localparam logic [3:0] CNT_LOW_FILL = 4'hf;
    localparam logic [6:0] RND_TRUNC = 7'h00;
    localparam logic [6:0] RND_8 = 7'h01;
    localparam logic [6:0] RND_10 = 7'h02;
    localparam logic [6:0] RND_12 = 7'h04;
    localparam logic [6:0] RND_14 = 7'h08;
    localparam logic [6:0] RND_16 = 7'h10;
    localparam logic [6:0] RND_20 = 7'h20;
    localparam logic [6:0] RND_24 = 7'h40;
    localparam logic [1:0] MUX_OFF = 2'h0;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
    } path_pair_t;
    typedef struct packed {
        logic [6:0] round;
        logic [3:0] exp;
        logic [3:0] frac;
    } gain_cfg_t;
endpackage

/* File: tb/output_sink.sv */
// downstream consumer that captures output word pairs on each valid strobe
`timescale 1ns/1ps
`default_nettype none
module output_sink
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic invert_in,
    input wire logic valid_strobe_in,
    input wire logic [15:0] word_a_in,
    input wire logic [15:0] word_b_in
);
    logic [15:0] got_a[$];
    logic [15:0] got_b[$];
    // take a word pair whenever the strobe is at its active level
    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            got_a.delete();
            got_b.delete();
        end
        else if (valid_strobe_in ^ invert_in)
        begin
            got_a.push_back(word_a_in);
            got_b.push_back(word_b_in);
        end
    end
endmodule
`default_nettype wire

/* File: tb/test_filter_output_stage.sv */
// self-checking bench for the filter output stage
`timescale 1ns/1ps
`default_nettype none
module test_filter_output_stage;
    import filter_out_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic sync_n = 1'b1;
    logic sv = 1'b0;
    logic inv = 1'b0;
    path_pair_t paths = '0;
    logic [31:0] rdat;
    logic ack, vs, ofa, ofb, tcs;
    logic [15:0] wa, wb;
    int error_cnt = 0;
    int checks = 0;
    logic [6:0] rc[8] = '{RND_TRUNC, RND_8, RND_10, RND_12, RND_14, RND_16, RND_20, RND_24};
    logic [31:0] rx[8] = '{32'h00018000, 32'h12800000, 32'h12200000, 32'h12380000,
        32'h12320000, 32'h00018000, 32'h1234fc00, 32'h1234ff80};
    logic [15:0] rw[8] = '{16'h0001, 16'h1300, 16'h1240, 16'h1240, 16'h1234, 16'h0002,
        16'h1235, 16'h1235};

    always #2 mclk_in = ~mclk_in;

    filter_output_stage uut (.mclk_in(mclk_in), .rst_in(rst_in), .cyc_in(cyc), .stb_in(stb),
        .we_in(we), .adr_in(adr), .sel_in(sel), .dat_in(wdat), .dat_out(rdat), .ack_out(ack),
        .sync_n_in(sync_n), .sample_valid_in(sv), .paths_in(paths), .path_a_word_out(wa),
        .path_b_word_out(wb), .valid_strobe_out(vs), .path_a_overflow_out(ofa),
        .path_b_overflow_out(ofb), .terminal_count_strobe_out(tcs));
    output_sink sink (.mclk_in(mclk_in), .rst_in(rst_in), .invert_in(inv),
        .valid_strobe_in(vs), .word_a_in(wa), .word_b_in(wb));

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [3:0] idx, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge mclk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= {idx, 2'h0};
        wdat <= {16'h0, d};
        do
        begin
            @(posedge mclk_in);
        end
        while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, idx, 16'h0, q);
        check("register", q, e);
    endtask

    task automatic send(input logic [31:0] a, input logic [31:0] b, input int cnt);
        @(posedge mclk_in);
        sv <= 1'b1;
        paths <= {a, b};
        repeat (cnt) @(posedge mclk_in);
        sv <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask

    task automatic take(input logic [15:0] ea, input logic [15:0] eb);
        logic [15:0] ga;
        logic [15:0] gb;
        ga = 16'hxxxx;
        gb = 16'hxxxx;
        if (sink.got_a.size() > 0)
        begin
            ga = sink.got_a.pop_front();
            gb = sink.got_b.pop_front();
        end
        check("words", {ga, gb}, {ea, eb});
    endtask

    task automatic setgain(input logic [15:0] g);
        wr(IDX_GAIN, g);
        send(32'h0, 32'h0, 1);
        sink.got_a.delete();
        sink.got_b.delete();
    endtask

    task automatic wait_tc(output int n);
        n = 0;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (tcs !== 1'b1 && n < 2000);
    endtask

    // sync held low two clocks so stages two and three agree; n counts from first low sample
    task automatic sync_pulse(output int n);
        sync_n <= 1'b0;
        repeat (2) @(posedge mclk_in);
        sync_n <= 1'b1;
        wait_tc(n);
        n = n + 1;
    endtask

    task automatic t_regs();
        for (int i = 5; i < 10; i++)
            rd_chk(4'(i), 16'h0000);
        wr(IDX_PERIOD, 16'h4321);
        rd_chk(IDX_PERIOD, 16'h4321);
        wr(IDX_GAIN, 16'h7f5a);
        rd_chk(IDX_GAIN, 16'h7f5a);
        wr(4'h9, 16'hffff);
        rd_chk(4'h9, 16'h0000);
    endtask

    task automatic t_counter();
        int n;
        wr(IDX_PERIOD, 16'h0001);
        wait_tc(n);
        sync_pulse(n);
        check("sync to strobe", n, 8);
        wait_tc(n);
        check("strobe period", n, 32);
        wr(IDX_CONTROL, 16'h0001);
        wait_tc(n);
        sync_pulse(n);
        check("free run", n, 31);
        wr(IDX_CONTROL, 16'h0000);
    endtask

    task automatic t_gain();
        for (int i = 0; i < 8; i++)
        begin
            setgain({1'b0, rc[i], 8'h00});
            send(rx[i], rx[i], 1);
            take(rw[i], rw[i]);
        end
        setgain(16'h0008);
        send(32'h10000000, 32'h10000000, 1);
        take(16'h1800, 16'h1800);
        wr(IDX_GAIN, 16'h0010);
        send(32'h10000000, 32'h10000000, 1);
        take(16'h1800, 16'h1800);
        send(32'h10000000, 32'h10000000, 1);
        take(16'h2000, 16'h2000);
        setgain(16'h0040);
        send(32'h10000000, 32'h01000000, 1);
        take(16'h7fff, 16'h1000);
        check("overflow", {ofa, ofb}, 2'b10);
        send(32'h01000000, 32'hc0000000, 1);
        take(16'h1000, 16'h8000);
        check("overflow", {ofa, ofb}, 2'b01);
        rd_chk(IDX_CONTROL, 16'h0004);
        setgain(16'h0000);
    endtask

    task automatic t_neg();
        logic [15:0] ga;
        logic [15:0] gb;
        logic [15:0] prev;
        for (int m = 0; m < 4; m++)
        begin
            wr(IDX_FORMAT, 16'(m));
            send(32'h10000000, 32'h10000000, 4);
            for (int k = 0; k < 4; k++)
            begin
                ga = sink.got_a.pop_front();
                gb = sink.got_b.pop_front();
                if (m == 0)
                    check("no negation", {ga, gb}, 32'h10001000);
                else if (ga === 16'hf000)
                    check("negation", gb, 16'h1000);
                else
                    check("negation", {ga, gb}, 32'h1000f000);
                if (m == 1 && k > 0)
                    check("full rate toggle", ga ^ prev, 16'he000);
                prev = ga;
            end
        end
    endtask

    task automatic t_fmt();
        wr(IDX_FORMAT, 16'h0008);
        send(32'h0, 32'h12345600, 1);
        take(16'h1234, 16'h5600);
        wr(IDX_FORMAT, 16'h004c);
        send(32'h12000000, 32'h00345600, 1);
        take(16'h1234, 16'h5600);
        for (int m = 1; m < 4; m += 2)
        begin
            wr(IDX_FORMAT, 16'(m << 4));
            send(32'h11110000, 32'h22220000, 1);
            take(16'h1111, 16'h0000);
            take(16'h2222, 16'h0000);
        end
        wr(IDX_FORMAT, 16'h0040);
        send(32'h10000000, 32'h20000000, 1);
        take(16'h1000, 16'h3000);
        wr(IDX_FORMAT, 16'h0080);
        repeat (2) @(posedge mclk_in);
        check("idle valid", vs, 1'b1);
        inv <= 1'b1;
        @(posedge mclk_in);
        sink.got_a.delete();
        sink.got_b.delete();
        send(32'h10000000, 32'h20000000, 1);
        take(16'h1000, 16'h2000);
        check("extra words", sink.got_a.size(), 0);
        wr(IDX_FORMAT, 16'h0000);
        repeat (2) @(posedge mclk_in);
        inv <= 1'b0;
    endtask

    initial
    begin
        #(4 * 40000);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_regs();
        t_counter();
        t_gain();
        t_neg();
        t_fmt();
        tally_and_finish();
    end
endmodule
`default_nettype wire
